// *** rtl/lsr_top.sv ***
// Limit switch reaction: warning flag, option code and drive state control.
// Assumes a motion core that brakes on request and reports standstill.
//
// Implementation choice: the Wishbone register port.
`default_nettype none

module lsr_top (
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      rstn_i,
    // Wishbone slave.
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [lsr_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [lsr_pkg::WB_DW-1:0] wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [lsr_pkg::WB_DW-1:0] wb_dat_o,
    output logic                           wb_ack_o,
    // Limit switches and motion core.
    input  wire logic [1:0]                lim_i,
    input  wire logic                      brake_done_i,
    output logic                           brake_o,
    output logic                           ramp_quick_o,
    output logic                           energized_o,
    output logic      [1:0]                state_o,
    output logic                           warn_o
);

    lsr_pkg::lsr_acc_s   acc;
    lsr_pkg::lsr_state_e state;
    lsr_pkg::lsr_state_e next_state;

    logic [15:0] code;
    logic [15:0] ctrl;
    logic        warn;
    logic        quick;
    logic        to_qsa;
    logic        qs_low_seen;
    logic        en_low_seen;
    logic        lim_evt;
    logic [31:0] rdat;

    // Bus front end and switch event detector.
    lsr_wb_slave u_wb (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_dat_i  (wb_dat_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .acc_o     (acc),
        .rdat_i    (rdat)
    );

    lsr_edge #(
        .N (2)
    ) u_edge (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .lim_i     (lim_i),
        .evt_o     (lim_evt)
    );

    // Register decode and byte-lane merge.
    wire wr_code = acc.wr && (acc.idx == lsr_pkg::CODE_IDX);
    wire wr_ctrl = acc.wr && (acc.idx == lsr_pkg::CTRL_IDX);
    wire wr_stat = acc.wr && (acc.idx == lsr_pkg::STAT_IDX);

    wire [15:0] code_wv = {acc.sel[1] ? acc.wdat[15:8] : code[15:8],
                           acc.sel[0] ? acc.wdat[7:0]  : code[7:0]};
    wire [15:0] ctrl_wv = {acc.sel[1] ? acc.wdat[15:8] : ctrl[15:8],
                           acc.sel[0] ? acc.wdat[7:0]  : ctrl[7:0]};
    wire        warn_clr = wr_stat && acc.sel[0] &&
                           acc.wdat[lsr_pkg::STAT_WARN_BIT];

    wire code_ok   = lsr_pkg::lsr_code_ok(code);
    wire code_brk  = lsr_pkg::lsr_brakes(code);
    wire qs_bit    = ctrl[lsr_pkg::CTRL_QS_BIT];
    wire en_bit    = ctrl[lsr_pkg::CTRL_EN_BIT];
    wire in_open   = (state == lsr_pkg::ST_OPEN);
    wire react     = lim_evt && in_open && code_brk;

    wire [15:0] stat_word = {8'h00,
                             warn,
                             1'b0,
                             ~code_ok,
                             (state == lsr_pkg::ST_BRAKE),
                             2'b00,
                             state};

    assign rdat = (acc.idx == lsr_pkg::CODE_IDX) ? {16'h0000, code} :
                  (acc.idx == lsr_pkg::CTRL_IDX) ? {16'h0000, ctrl} :
                  (acc.idx == lsr_pkg::STAT_IDX) ? {16'h0000, stat_word} :
                  32'h0000_0000;

    // bus-only control
    // Registers written by software; ctrl changes only on a bus write.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            code <= lsr_pkg::CODE_RST;
            ctrl <= lsr_pkg::CTRL_RST;
        end else begin
            if (wr_code) begin
                code <= code_wv;
            end
            if (wr_ctrl) begin
                ctrl <= ctrl_wv;
            end
        end
    end

    // sticky warning
    // A new switch event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warn <= 1'b0;
        end else if (lim_evt) begin
            warn <= 1'b1;
        end else if (warn_clr) begin
            warn <= 1'b0;
        end
    end

    // ramp and target
    // The ramp and the end state are latched when braking starts.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quick  <= 1'b0;
            to_qsa <= 1'b0;
        end else if (react) begin
            quick  <= (code == lsr_pkg::OPT_QUICK_SOD) ||
                      (code == lsr_pkg::OPT_QUICK_QSA);
            to_qsa <= (code == lsr_pkg::OPT_SLOW_QSA) ||
                      (code == lsr_pkg::OPT_QUICK_QSA);
        end
    end

    // low then high
    // The quick-stop bit must be seen low inside Quick stop active first.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qs_low_seen <= 1'b0;
        end else if (state != lsr_pkg::ST_QSA) begin
            qs_low_seen <= 1'b0;
        end else if (!qs_bit) begin
            qs_low_seen <= 1'b1;
        end
    end

    // stay disabled
    // Switch on disabled is left only once enable was seen low there.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_low_seen <= 1'b0;
        end else if (state != lsr_pkg::ST_SOD) begin
            en_low_seen <= 1'b0;
        end else if (!en_bit) begin
            en_low_seen <= 1'b1;
        end
    end

    // Drive state transitions.
    always_comb begin
        next_state = state;
        unique case (state)
            lsr_pkg::ST_SOD: begin
                if (en_low_seen && en_bit && qs_bit) begin
                    next_state = lsr_pkg::ST_OPEN;
                end
            end
            lsr_pkg::ST_OPEN: begin
                if (react) begin
                    next_state = lsr_pkg::ST_BRAKE;
                end else if (!en_bit) begin
                    next_state = lsr_pkg::ST_SOD;
                end
            end
            lsr_pkg::ST_BRAKE: begin
                if (brake_done_i) begin
                    next_state = to_qsa ? lsr_pkg::ST_QSA
                                        : lsr_pkg::ST_SOD;
                end
            end
            lsr_pkg::ST_QSA: begin
                if (!en_bit) begin
                    next_state = lsr_pkg::ST_SOD;
                end else if (qs_low_seen && qs_bit) begin
                    next_state = lsr_pkg::ST_OPEN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= lsr_pkg::ST_SOD;
        end else begin
            state <= next_state;
        end
    end

    // Outputs; the motor stays energized through Quick stop active.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brake_o      <= 1'b0;
            ramp_quick_o <= 1'b0;
            energized_o  <= 1'b0;
            state_o      <= 2'b00;
            warn_o       <= 1'b0;
        end else begin
            brake_o      <= (next_state == lsr_pkg::ST_BRAKE);
            ramp_quick_o <= (next_state == lsr_pkg::ST_BRAKE) &&
                            (react ? ((code == lsr_pkg::OPT_QUICK_SOD) ||
                                      (code == lsr_pkg::OPT_QUICK_QSA))
                                   : quick);
            energized_o  <= (next_state != lsr_pkg::ST_SOD);
            state_o      <= next_state;
            warn_o       <= lim_evt | (warn & ~warn_clr);
        end
    end

    // Checks on the reaction logic.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_warn_set;
        lim_evt |=> warn ##1 warn_o;
    endproperty
    a_warn_set: assert property (p_warn_set)
        else $error("warning bit not set after a switch event");

    property p_no_reaction;
        lim_evt && in_open && (code == lsr_pkg::OPT_NONE) && en_bit
            |=> (state == lsr_pkg::ST_OPEN) [*2];
    endproperty
    a_no_reaction: assert property (p_no_reaction)
        else $error("code -1 left operation enabled");

    property p_brake_sod;
        (state == lsr_pkg::ST_BRAKE) && !to_qsa && brake_done_i
            |=> (state == lsr_pkg::ST_SOD) ##1 !energized_o;
    endproperty
    a_brake_sod: assert property (p_brake_sod)
        else $error("codes 1 and 2 did not end in switch on disabled");

    property p_ramp_sel;
        react |=> brake_o && (ramp_quick_o == $past(code[1]));
    endproperty
    a_ramp_sel: assert property (p_ramp_sel)
        else $error("wrong ramp selected for the reaction");

    property p_brake_qsa;
        (state == lsr_pkg::ST_BRAKE) && to_qsa && brake_done_i
            |=> (state == lsr_pkg::ST_QSA) ##1 (energized_o && !brake_o);
    endproperty
    a_brake_qsa: assert property (p_brake_qsa)
        else $error("codes 5 and 6 did not end in quick stop active");

    property p_qs_kept;
        (state == lsr_pkg::ST_BRAKE) && !wr_ctrl
            |=> $stable(ctrl[lsr_pkg::CTRL_QS_BIT]);
    endproperty
    a_qs_kept: assert property (p_qs_kept)
        else $error("quick-stop control bit changed without a write");

    property p_qsa_return;
        (state == lsr_pkg::ST_QSA) && en_bit && qs_bit && !qs_low_seen
            |=> state != lsr_pkg::ST_OPEN;
    endproperty
    a_qsa_return: assert property (p_qsa_return)
        else $error("left quick stop active without a 0 then 1 toggle");

    property p_unsupported;
        lim_evt && in_open && !code_ok && en_bit
            |=> (state == lsr_pkg::ST_OPEN) && !brake_o;
    endproperty
    a_unsupported: assert property (p_unsupported)
        else $error("unsupported code started a braking reaction");

    c_brake_sod: cover property (
        react ##[1:20] (state == lsr_pkg::ST_SOD));
    c_brake_qsa: cover property (
        (state == lsr_pkg::ST_QSA) ##[1:40] (state == lsr_pkg::ST_OPEN));
    c_homing: cover property (
        lim_evt && in_open && (code == lsr_pkg::OPT_NONE));
    c_set_clear: cover property (lim_evt && warn_clr);

endmodule

`default_nettype wire

// *** rtl/lsr_pkg.sv ***
// Constants, types and helpers shared by the limit switch reaction block.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
`default_nettype none

package lsr_pkg;

    // Bus geometry.
    localparam int unsigned WB_AW = 16;
    localparam int unsigned WB_DW = 32;
    localparam int unsigned IDX_W = 14;

    // Register indices; the byte address is four times the index.
    localparam logic [13:0] CODE_IDX = 14'h3701;
    localparam logic [13:0] CTRL_IDX = 14'h3710;
    localparam logic [13:0] STAT_IDX = 14'h3711;

    // Reset values.
    localparam logic [15:0] CODE_RST = 16'hFFFF;
    localparam logic [15:0] CTRL_RST = 16'h0004;

    // Reaction option codes (signed 16-bit values).
    localparam logic [15:0] OPT_NONE      = 16'hFFFF;
    localparam logic [15:0] OPT_SLOW_SOD  = 16'h0001;
    localparam logic [15:0] OPT_QUICK_SOD = 16'h0002;
    localparam logic [15:0] OPT_SLOW_QSA  = 16'h0005;
    localparam logic [15:0] OPT_QUICK_QSA = 16'h0006;

    // Control word fields.
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_QS_BIT = 2;

    // Status word fields.
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_BRAKE_BIT = 4;
    localparam int unsigned STAT_UNSUP_BIT = 5;
    localparam int unsigned STAT_WARN_BIT  = 7;

    typedef enum logic [1:0] {
        ST_SOD,
        ST_OPEN,
        ST_BRAKE,
        ST_QSA
    } lsr_state_e;

    // One register access taken from the bus, valid for one cycle.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [IDX_W-1:0]  idx;
        logic [WB_DW-1:0]  wdat;
        logic [3:0]        sel;
    } lsr_acc_s;

    // True for the option codes that select a braking reaction.
    function automatic logic lsr_brakes(input logic [15:0] c);
        return (c == OPT_SLOW_SOD) || (c == OPT_QUICK_SOD) ||
               (c == OPT_SLOW_QSA) || (c == OPT_QUICK_QSA);
    endfunction

    // True for every option code that the block supports.
    function automatic logic lsr_code_ok(input logic [15:0] c);
        return lsr_brakes(c) || (c == OPT_NONE);
    endfunction

endpackage

`default_nettype wire

// *** rtl/lsr_edge.sv ***
// Detects a limit switch being reached on any of the switch inputs.
// Assumes the switch inputs are already synchronous to the clock.
`default_nettype none

module lsr_edge #(
    parameter int unsigned N = 2
) (
    // Clock and reset.
    input  wire logic         sys_clk_i,
    input  wire logic         rstn_i,
    // Switch levels and event.
    input  wire logic [N-1:0] lim_i,
    output logic              evt_o
);

    logic [N-1:0] prev;
    logic [N-1:0] rise;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sw
            assign rise[g] = lim_i[g] & ~prev[g];
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    prev[g] <= 1'b0;
                end else begin
                    prev[g] <= lim_i[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evt_o <= 1'b0;
        end else begin
            evt_o <= |rise;
        end
    end

endmodule

`default_nettype wire

// *** rtl/lsr_wb_slave.sv ***
// Classic Wishbone slave front end: takes one access, answers one cycle on.
// Assumes a master that holds its request until it samples ack high.
`default_nettype none

module lsr_wb_slave (
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      rstn_i,
    // Wishbone slave.
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [lsr_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [lsr_pkg::WB_DW-1:0] wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [lsr_pkg::WB_DW-1:0] wb_dat_o,
    output logic                           wb_ack_o,
    // Register side.
    output lsr_pkg::lsr_acc_s              acc_o,
    input  wire logic [lsr_pkg::WB_DW-1:0] rdat_i
);

    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    assign acc_o.wr   = take & wb_we_i;
    assign acc_o.rd   = take & ~wb_we_i;
    assign acc_o.idx  = wb_adr_i[lsr_pkg::WB_AW-1:2];
    assign acc_o.wdat = wb_dat_i;
    assign acc_o.sel  = wb_sel_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= take;
            if (acc_o.rd) begin
                wb_dat_o <= rdat_i;
            end
        end
    end

endmodule

`default_nettype wire

// *** dv/lsr_motion_model.sv ***
// Far-side model: two limit switches and a motion core that brakes.
// Assumes the bench requests switch passes and sets the braking time.
`default_nettype none

module lsr_motion_model (
    // Clock and reset.
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // Requests from the bench.
    input  wire logic       pass_i,
    input  wire logic       pass_idx_i,
    input  wire logic [3:0] delay_i,
    // Toward the block.
    input  wire logic       brake_i,
    output logic      [1:0] lim_o,
    output logic            brake_done_o
);
    logic [2:0] hold;
    logic [3:0] cnt;

    // The switch is closed for four cycles, then the axle has moved past it.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lim_o <= 2'b00;
            hold  <= 3'd0;
            cnt   <= 4'h0;
        end else begin
            if (pass_i) begin
                lim_o[pass_idx_i] <= 1'b1;
                hold              <= 3'd4;
            end else if (hold != 3'd0) begin
                hold <= hold - 3'd1;
                if (hold == 3'd1) begin
                    lim_o <= 2'b00;
                end
            end
            if (!brake_i) begin
                cnt <= 4'h0;
            end else if (cnt != 4'hF) begin
                cnt <= cnt + 4'h1;
            end
        end
    end

    // Standstill is reported only while braking is requested.
    assign brake_done_o = brake_i && (cnt >= delay_i);
endmodule

`default_nettype wire

// *** dv/lsr_top_bench.sv ***
// Self-checking bench for the limit switch reaction block.
// Assumes the package, the design files and the motion model come first.
`default_nettype none

module lsr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] A_CODE = {lsr_pkg::CODE_IDX, 2'b00};
    localparam logic [15:0] A_CTRL = {lsr_pkg::CTRL_IDX, 2'b00};
    localparam logic [15:0] A_STAT = {lsr_pkg::STAT_IDX, 2'b00};
    localparam logic [15:0] CODES [5] = '{lsr_pkg::OPT_SLOW_SOD,
        lsr_pkg::OPT_QUICK_SOD, lsr_pkg::OPT_SLOW_QSA,
        lsr_pkg::OPT_QUICK_QSA, lsr_pkg::OPT_NONE};

    logic        sys_clk  = 1'b0;
    logic        rstn     = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [15:0] wb_adr   = 16'h0000;
    logic [31:0] wb_wdat  = 32'h0000_0000;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        pass     = 1'b0;
    logic        pass_idx = 1'b0;
    logic [3:0]  delay    = 4'h4;
    logic [1:0]  lim;
    logic        brake_done;
    logic        brake;
    logic        ramp_quick;
    logic        energized;
    logic        warn;
    logic [1:0]  state;
    logic [31:0] r;
    int          fails    = 0;
    int          n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    lsr_top u_dut (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .lim_i(lim), .brake_done_i(brake_done),
        .brake_o(brake), .ramp_quick_o(ramp_quick),
        .energized_o(energized), .state_o(state), .warn_o(warn)
    );

    lsr_motion_model u_far (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .pass_i(pass),
        .pass_idx_i(pass_idx), .delay_i(delay), .brake_i(brake),
        .lim_o(lim), .brake_done_o(brake_done)
    );

    function automatic logic is_brake(input logic [15:0] c);
        return c == 16'h0001 || c == 16'h0002 || c == 16'h0005 ||
               c == 16'h0006;
    endfunction

    function automatic logic is_sup(input logic [15:0] c);
        return is_brake(c) || c == 16'hFFFF;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic hang();
        fails++;
        test_done();
    endtask

    task automatic wb(input logic we, input logic [15:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        wb_sel  <= s;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) hang();
        r = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        while (state !== s && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        if (state !== s) hang();
    endtask

    task automatic go_open();
        wb(1'b1, A_CTRL, 32'h0000_0000, 4'h3);
        wb(1'b1, A_CTRL, 32'h0000_0005, 4'h3);
        wait_state(2'd1);
        wb(1'b1, A_STAT, 32'h0000_0080, 4'h1);
        @(posedge sys_clk);
        chk(warn, 1'b0);
    endtask

    task automatic react(input logic [15:0] c);
        logic qsa;
        int   n;
        qsa = (c == 16'h0005) || (c == 16'h0006);
        n = 0;
        go_open();
        wb(1'b1, A_CODE, {16'h0000, c}, 4'h3);
        delay    <= 4'(4 + $urandom_range(7));
        pass_idx <= 1'($urandom_range(1));
        pass     <= 1'b1;
        @(posedge sys_clk);
        pass <= 1'b0;
        while (warn !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            n++;
        end
        if (warn !== 1'b1) hang();
        if (is_brake(c)) begin
            chk(state, 2'd2);
            chk(brake, 1'b1);
            chk(ramp_quick, c == 16'h0002 || c == 16'h0006);
            wait_state(qsa ? 2'd3 : 2'd0);
            chk(energized, qsa);
            chk(brake, 1'b0);
            wb(1'b0, A_CTRL, 32'h0000_0000, 4'hF);
            chk(r[2], 1'b1);
            if (qsa) begin
                wb(1'b1, A_CTRL, 32'h0000_0005, 4'h3);
                chk(state, 2'd3);
                wb(1'b1, A_CTRL, 32'h0000_0001, 4'h3);
                chk(state, 2'd3);
                wb(1'b1, A_CTRL, 32'h0000_0005, 4'h3);
                wait_state(2'd1);
                chk(energized, 1'b1);
            end
        end else begin
            repeat (4) @(posedge sys_clk);
            chk(state, 2'd1);
            chk(brake, 1'b0);
        end
        wb(1'b0, A_STAT, 32'h0000_0000, 4'hF);
        chk(r[7], 1'b1);
        chk(r[5], !is_sup(c));
        chk(r[1:0], (is_brake(c) && !qsa) ? 2'd0 : 2'd1);
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        hang();
    end

    initial begin
        logic [15:0] u;
        void'($urandom(32'h5f18));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, A_CODE, 32'h0000_0000, 4'hF);
        chk(r, 32'h0000_FFFF);
        wb(1'b0, A_CTRL, 32'h0000_0000, 4'hF);
        chk(r, 32'h0000_0004);
        chk(energized, 1'b0);
        wb(1'b1, 16'h0010, $urandom, 4'hF);
        wb(1'b0, 16'h0010, 32'h0000_0000, 4'hF);
        chk(r, 32'h0000_0000);
        wb(1'b1, A_CODE, 32'h0000_1234, 4'h1);
        wb(1'b0, A_CODE, 32'h0000_0000, 4'hF);
        chk(r, 32'h0000_FF34);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 5; i++) begin
                react(CODES[i]);
            end
            do begin
                u = 16'($urandom);
            end while (is_sup(u));
            react(u);
        end
        test_done();
    end
endmodule

`default_nettype wire
